// ==== core/rbbs_addr_gen.sv ====
`timescale 1ns/100ps
// resolves the 8-bit register field into a full data memory address
module rbbs_addr_gen import rbbs_pkg::*; (
   input wire logic [7:0] regField,
   input wire logic accFlag,
   input wire logic extEnable,
   input wire logic [3:0] bankSelect,
   input wire logic [ADR_W-1:0] indexBase,
   output logic [ADR_W-1:0] memAddr
);
   // pure combinational; caller registers the result
   always_comb begin
      if (accFlag) begin
         memAddr = {bankSelect, regField};
      end else if (extEnable && (regField <= IDX_LIM)) begin
         // indexed literal offset replaces the access bank low part up to IDX_LIM
         memAddr = indexBase + {4'h0, regField};
      end else if (regField <= ACC_LO_LIM) begin
         memAddr = {4'h0, regField};
      end else begin
         memAddr = {ACC_HI_BANK, regField};
      end
   end
endmodule // rbbs_addr_gen

// ==== core/rbbs_exec.sv ====
`timescale 1ns/100ps
module rbbs_exec import rbbs_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   input wire logic [PC_W-1:0] pcNext,
   input wire logic [3:0] bankSelect,
   input wire logic extEnable,
   input wire logic [ADR_W-1:0] indexBase,
   input wire logic [7:0] memRdata,
   output logic [1:0] phase,
   output logic pcLoad,
   output logic [PC_W-1:0] pcTarget,
   output logic flushActive,
   output rbbs_mem_s memReq,
   output logic statusWrite
);
   rbbs_phase_e phase_ff; // quarter phase of the instruction cycle
   logic [15:0] ir_ff; // word latched at Q1
   logic irValid_ff; // latched word is real
   logic flush_ff; // second, idle cycle of the branch
   logic pcLoad_ff;
   logic [PC_W-1:0] pcTarget_ff;
   rbbs_mem_s memReq_ff;
   logic [ADR_W-1:0] resolvedAddr; // operand address from the bank logic
   logic isBranch; // decoded unconditional_relative_branch
   logic isBitSet; // decoded set_register_bit
   logic [PC_W-1:0] branchDisp; // sign extended 2n

   // decode works on the latched word; an idle flush cycle decodes nothing
   assign isBranch = irValid_ff && !flush_ff && (ir_ff[15:11] == BRANCH_OPC);
   assign isBitSet = irValid_ff && !flush_ff && (ir_ff[15:12] == BITSET_OPC);
   // offset doubled: word offset into a byte-addressed PC
   assign branchDisp = {{(PC_W-OFS_W-1){ir_ff[OFS_W-1]}}, ir_ff[OFS_W-1:0], 1'b0};

   rbbs_addr_gen i_rbbs_addr_gen (
      .regField(ir_ff[7:0]),
      .accFlag(ir_ff[8]),
      .extEnable(extEnable),
      .bankSelect(bankSelect),
      .indexBase(indexBase),
      .memAddr(resolvedAddr)
   );

   // four-phase sequencer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_ff <= RBBS_Q1;
      end else begin
         case (phase_ff)
            RBBS_Q1: phase_ff <= RBBS_Q2;
            RBBS_Q2: phase_ff <= RBBS_Q3;
            RBBS_Q3: phase_ff <= RBBS_Q4;
            RBBS_Q4: phase_ff <= RBBS_Q1;
            default: phase_ff <= RBBS_Q1;
         endcase
      end
   end

   // instruction latch at Q1 decode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ir_ff <= 16'h0000;
         irValid_ff <= 1'b0;
      end else if (phase_ff == RBBS_Q4) begin
         ir_ff <= instrWord;
         irValid_ff <= instrValid;
      end
   end

   // flush marks the cycle after a taken branch; the prefetched word is dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flush_ff <= 1'b0;
      end else if (phase_ff == RBBS_Q4) begin
         flush_ff <= isBranch;
      end
   end

   // program counter write at Q4 of the branch cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pcLoad_ff <= 1'b0;
         pcTarget_ff <= PC_RESET;
      end else begin
         pcLoad_ff <= 1'b0;
         if (phase_ff == RBBS_Q3 && isBranch) begin
            // pcNext already holds PC+2 from the fetch
            pcTarget_ff <= pcNext + branchDisp;
            pcLoad_ff <= 1'b1;
         end
      end
   end

   // read-modify-write: read at Q2, write at Q4
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         memReq_ff <= '0;
      end else begin
         memReq_ff.rd <= 1'b0;
         memReq_ff.wr <= 1'b0;
         if (isBitSet) begin
            if (phase_ff == RBBS_Q1) begin
               memReq_ff.rd <= 1'b1;
               memReq_ff.adr <= resolvedAddr;
            end else if (phase_ff == RBBS_Q3) begin
               // data returned during Q2 is modified here
               memReq_ff.wr <= 1'b1;
               memReq_ff.wdat <= memRdata | (8'h01 << ir_ff[11:9]);
            end
         end
      end
   end

   assign phase = phase_ff;
   assign pcLoad = pcLoad_ff;
   assign pcTarget = pcTarget_ff;
   assign flushActive = flush_ff;
   assign memReq = memReq_ff;
   // neither instruction touches the status flags
   assign statusWrite = 1'b0;

   // branch target equals advanced PC plus doubled, sign extended word offset
   property p_branch_target;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q3 && isBranch) |=> pcLoad_ff &&
         (pcTarget_ff == $past(pcNext) + {{(PC_W-OFS_W-1){$past(ir_ff[OFS_W-1])}},
         $past(ir_ff[OFS_W-1:0]), 1'b0});
   endproperty
   a_branch_target: assert property (p_branch_target) else $error("bad branch target");

   property p_branch_flush;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q4 && isBranch) |=> flush_ff [*4];
   endproperty
   a_branch_flush: assert property (p_branch_flush) else $error("branch idle cycle missing");

   // the idle cycle may neither touch memory nor reload the PC
   property p_flush_idle;
      @(posedge sys_clk) disable iff (rst)
      flush_ff |-> !memReq_ff.rd && !memReq_ff.wr && !pcLoad_ff;
   endproperty
   a_flush_idle: assert property (p_flush_idle) else $error("activity in idle cycle");

   property p_pcload_one;
      @(posedge sys_clk) disable iff (rst)
      pcLoad_ff |-> phase_ff == RBBS_Q4 && !$past(pcLoad_ff);
   endproperty
   a_pcload_one: assert property (p_pcload_one) else $error("pc load misplaced");

   property p_bitset_write;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q1 && isBitSet) |=> memReq_ff.rd ##2 memReq_ff.wr &&
         memReq_ff.wdat[ir_ff[11:9]];
   endproperty
   a_bitset_write: assert property (p_bitset_write) else $error("bit set write wrong");

   property p_bitset_bank;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q1 && isBitSet && ir_ff[8]) |=>
         memReq_ff.adr == {$past(bankSelect), $past(ir_ff[7:0])};
   endproperty
   a_bitset_bank: assert property (p_bitset_bank) else $error("banked address wrong");

   // access bank also applies with the extended set on, above the indexed range
   property p_bitset_access;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q1 && isBitSet && !ir_ff[8]
         && !(extEnable && ir_ff[7:0] <= IDX_LIM)) |=>
         memReq_ff.adr == {($past(ir_ff[7]) ? ACC_HI_BANK : 4'h0), $past(ir_ff[7:0])};
   endproperty
   a_bitset_access: assert property (p_bitset_access) else $error("access bank wrong");

   property p_bitset_index;
      @(posedge sys_clk) disable iff (rst)
      (phase_ff == RBBS_Q1 && isBitSet && !ir_ff[8] && extEnable
         && ir_ff[7:0] <= IDX_LIM) |=>
         memReq_ff.adr == $past(indexBase) + {4'h0, $past(ir_ff[7:0])};
   endproperty
   a_bitset_index: assert property (p_bitset_index) else $error("indexed address wrong");

   property p_decode;
      @(posedge sys_clk) disable iff (rst)
      pcLoad_ff |-> $past(ir_ff[15:11]) == BRANCH_OPC;
   endproperty
   a_decode: assert property (p_decode) else $error("load without branch opcode");
endmodule // rbbs_exec

// ==== pkg/rbbs_pkg.sv ====
package rbbs_pkg;
   // opcode fields, widths, address limits and reset values of the core
   localparam logic [4:0] BRANCH_OPC = 5'h1A; // top five bits 1101_0 of the branch
   localparam logic [3:0] BITSET_OPC = 4'h8; // top four bits 1000 of the bit set
   localparam int OFS_W = 11; // branch offset width
   localparam int PC_W = 21; // program counter width
   localparam int ADR_W = 12; // data memory address width
   localparam logic [7:0] IDX_LIM = 8'h5F; // indexed literal offset limit
   localparam logic [7:0] ACC_LO_LIM = 8'h7F; // access bank: low part ends here
   localparam logic [3:0] ACC_HI_BANK = 4'hF; // access bank upper half bank
   localparam logic [1:0] Q_RESET = 2'h0; // phase counter reset value
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

   // quarter phases of one instruction cycle, gray ordered
   typedef enum logic [1:0] {
      RBBS_Q1 = 2'b00,
      RBBS_Q2 = 2'b01,
      RBBS_Q3 = 2'b11,
      RBBS_Q4 = 2'b10
   } rbbs_phase_e;

   // data memory request carried as a group
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADR_W-1:0] adr;
      logic [7:0] wdat;
   } rbbs_mem_s;
endpackage

// ==== tb/rbbs_bench.sv ====
`timescale 1ns/100ps
module rbbs_bench import rbbs_pkg::*;;
   logic sys_clk = 1'b0; // core clock, 40 ns
   logic rst = 1'b1; // held for ten cycles at start
   logic [15:0] instrWord = 16'h0000;
   logic instrValid = 1'b0;
   logic [PC_W-1:0] pcNext = 21'h000000;
   logic [3:0] bankSelect = 4'h0;
   logic extEnable = 1'b0;
   logic [ADR_W-1:0] indexBase = 12'h300; // fixed base for indexed mode
   logic [7:0] memRdata = 8'h00;
   logic [1:0] phase;
   logic pcLoad;
   logic flushActive;
   logic statusWrite;
   logic [PC_W-1:0] pcTarget;
   rbbs_mem_s memReq;
   int n_errors = 0;
   int n_checks = 0;
   int nCyc = 0; // hang guard
   int nRd, nWr, nLd, nFl, nOdd; // pulses seen in one instruction cycle
   logic [ADR_W-1:0] gotAdr;
   logic [7:0] gotDat;
   logic [PC_W-1:0] gotTgt;

   rbbs_exec i_rbbs_exec (.sys_clk(sys_clk), .rst(rst), .instrWord(instrWord),
      .instrValid(instrValid), .pcNext(pcNext), .bankSelect(bankSelect),
      .extEnable(extEnable), .indexBase(indexBase), .memRdata(memRdata), .phase(phase),
      .pcLoad(pcLoad), .pcTarget(pcTarget), .flushActive(flushActive), .memReq(memReq),
      .statusWrite(statusWrite));

   // free running clock
   always #20 sys_clk = ~sys_clk;

   // whole run needs about 110 cycles, so 1000 means a hang
   always @(posedge sys_clk) begin
      nCyc++;
      if (nCyc > 1000) begin
         n_errors++;
         wrap_up();
      end
   end

   task wrap_up;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a pulse in the wrong quarter is counted as odd, not as a hit
   task sample;
      if (memReq.rd === 1'b1) begin
         if (phase === RBBS_Q2) nRd++; else nOdd++;
         gotAdr = memReq.adr;
      end
      if (memReq.wr === 1'b1) begin
         if (phase === RBBS_Q4) nWr++; else nOdd++;
         gotDat = memReq.wdat;
      end
      if (pcLoad === 1'b1) begin
         if (phase === RBBS_Q4) nLd++; else nOdd++;
         gotTgt = pcTarget;
      end
      if (flushActive === 1'b1) nFl++;
      if (statusWrite !== 1'b0) nOdd++; // flags never touched
   endtask

   // present one word at Q4, then watch the four quarters that execute it
   task run(input logic [15:0] w, input logic [PC_W-1:0] pc);
      int i;
      i = 0;
      while (phase !== RBBS_Q4 && i < 8) begin
         @(posedge sys_clk);
         #1;
         i++;
      end
      instrWord = w;
      instrValid = 1'b1;
      pcNext = pc; // held through the processing quarters
      nRd = 0; nWr = 0; nLd = 0; nFl = 0; nOdd = 0;
      @(posedge sys_clk);
      #1;
      instrValid = 1'b0;
      sample();
      repeat (3) begin
         @(posedge sys_clk);
         #1;
         sample();
      end
   endtask

   // branch, then an idle cycle that must swallow the following word
   task do_branch(input logic [10:0] n, input logic [PC_W-1:0] pc);
      logic [PC_W-1:0] exp;
      exp = pc + {{(PC_W-12){n[10]}}, n, 1'b0};
      run({BRANCH_OPC, n}, pc);
      chk(nLd, 1);
      chk(gotTgt, exp);
      chk(nRd + nWr + nFl + nOdd, 0);
      run(16'h8E05, pc);
      chk(nFl, 4);
      chk(nRd + nWr + nLd + nOdd, 0);
   endtask

   // one bit set with its expected data address
   task do_bit_set(input logic [2:0] b, input logic a, input logic [7:0] f, input logic ext,
      input logic [ADR_W-1:0] adr);
      extEnable = ext;
      memRdata = f ^ 8'hA5; // some bits already set, some not
      run({BITSET_OPC, b, a, f}, 21'h000100);
      chk(nRd, 1);
      chk(nWr, 1);
      chk(gotAdr, adr);
      chk(gotDat, (f ^ 8'hA5) | (8'h01 << b));
      chk(nLd + nFl + nOdd, 0);
   endtask

   // reset right after a branch loaded the PC: outputs clear, the idle cycle never comes
   task reset_mid;
      run({BRANCH_OPC, 11'h010}, 21'h000040);
      chk(nLd, 1);
      rst = 1'b1;
      @(posedge sys_clk);
      #1;
      chk(phase, RBBS_Q1);
      chk({pcLoad, flushActive, memReq.rd, memReq.wr, statusWrite}, 0);
      chk({memReq.adr, memReq.wdat}, 0);
      chk(pcTarget, 0);
      rst = 1'b0;
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      do_branch(11'h3FF, 21'h001000);
      do_branch(11'h400, 21'h001000);
      do_branch(11'h001, 21'h1FFFFE);
      reset_mid();
      bankSelect = 4'h3;
      // first bit set after the reset must run with no idle cycle in front
      for (int k = 0; k < 8; k++) do_bit_set(k[2:0], 1'b1, 8'h21, 1'b0, 12'h321);
      bankSelect = 4'h5;
      do_bit_set(3'h7, 1'b1, 8'h10, 1'b1, 12'h510);
      do_bit_set(3'h2, 1'b0, 8'h7F, 1'b0, 12'h07F);
      do_bit_set(3'h0, 1'b0, 8'h80, 1'b0, 12'hF80);
      do_bit_set(3'h3, 1'b0, 8'h5F, 1'b1, 12'h35F);
      do_bit_set(3'h5, 1'b0, 8'h00, 1'b1, 12'h300);
      do_bit_set(3'h4, 1'b0, 8'h60, 1'b1, 12'h060);
      do_branch(11'h555, 21'h000200);
      wrap_up();
   end
endmodule // rbbs_bench
